// ===== edge_select_pkg.sv
/*
 * Shared constants and types for the clock-edge / polarity select block.
 * Assumes every user sits on the single core_clk domain with a synchronous,
 * active-high reset; pins are synchronised before use.
 */
package edge_select_pkg;

	// clock of the block, for reference in timing arithmetic
	localparam int CORE_CLK_PERIOD_NS = 4;

	// synchroniser depth ahead of any logic
	localparam int SYNC_STAGES = 2;

	// bit positions inside the synchronised pin vector
	localparam int PIN_EDGE_SEL = 0;
	localparam int PIN_MODE = 1;
	localparam int PIN_RX_CLK = 2;
	localparam int PIN_SHIFT_CLK = 3;
	localparam int PIN_RX_NRZ = 4;
	localparam int PIN_RX_POS = 5;
	localparam int PIN_RX_NEG = 6;
	localparam int PIN_COUNT = 7;

	// reset values of the outputs
	localparam logic RX_CLK_RESET = 1'h0;
	localparam logic RX_DATA_RESET = 1'h0;
	localparam logic SERIAL_OUT_RESET = 1'h0;
	localparam logic SERIAL_OE_N_RESET = 1'h1;

	// receive path operating mode
	typedef enum logic {
		MODE_CLOCK_RECOVERY,
		MODE_DATA_RECOVERY
	} rx_mode_t;

	// chooses which detected edge launches new output data:
	// select high launches on the rising edge, low on the falling edge
	function automatic logic launch_now(input logic sel, input logic rise, input logic fall);
		launch_now = sel ? rise : fall;
	endfunction : launch_now

endpackage : edge_select_pkg

// ===== pin_sync.sv
/*
 * Two-stage synchroniser with edge detection for a vector of pins.
 * Assumes the inputs are asynchronous to core_clk and change slowly
 * compared to its 4 ns period.
 */
`timescale 1ns/1ns
module pin_sync
	import edge_select_pkg::*;
#(
	parameter int WIDTH = PIN_COUNT
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// raw pins
	input wire logic [WIDTH-1:0] pin_in,
	// synchronised level and one-cycle edge pulses
	output logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] rise,
	output logic [WIDTH-1:0] fall
);

	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
		logic [WIDTH-1:0] prev;
	} sync_state_t;

	sync_state_t st_r;
	sync_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.meta = pin_in;
		st_nxt.stable = st_r.meta;
		st_nxt.prev = st_r.stable;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_r <= '0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// meta stage is read only by the stable stage
	assign level = st_r.stable;
	assign rise = st_r.stable & ~st_r.prev;
	assign fall = ~st_r.stable & st_r.prev;

endmodule : pin_sync

// ===== edge_select.sv
/*
 * Receive output timing and polarity control driven by the static
 * edge-select pin, plus the launch edge of the serial read output.
 * Assumes the recovered receive clock, the shift clock and all pins are
 * asynchronous and much slower than core_clk (the recovered clock near
 * 12.5 MHz at most), so that every edge is seen by sampling.
 * The serial read bit and its active flag come from core_clk logic.
 */
`timescale 1ns/1ns

module edge_select
	import edge_select_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// static configuration pins
	input wire logic edge_select_pin,
	input wire logic data_recovery_pin,
	// receive side from the line front end
	input wire logic rx_clk_in,
	input wire logic rx_nrz_in,
	input wire logic rx_pos_in,
	input wire logic rx_neg_in,
	// receive outputs toward the framer
	output logic rx_clk_out,
	output logic rx_data_out,
	output logic rx_positive_rail,
	output logic rx_negative_rail,
	// serial control read side
	input wire logic shift_clk_pin,
	input wire logic read_bit,
	input wire logic read_active,
	output logic serial_read_output,
	output logic serial_read_oe_n
);

	typedef struct packed {
		logic edge_sel;
		rx_mode_t mode;
		logic rx_clk;
		logic nrz;
		logic pos;
		logic neg;
		logic ser_out;
		logic ser_oe_n;
	} ctrl_state_t;

	ctrl_state_t st_r;
	ctrl_state_t st_nxt;

	logic [PIN_COUNT-1:0] pins_raw;
	logic [PIN_COUNT-1:0] pins;
	logic [PIN_COUNT-1:0] pins_rise;
	logic [PIN_COUNT-1:0] pins_fall;
	logic sel_now;
	rx_mode_t mode_now;
	logic rx_launch;
	logic ser_launch;

	assign pins_raw[PIN_EDGE_SEL] = edge_select_pin;
	assign pins_raw[PIN_MODE] = data_recovery_pin;
	assign pins_raw[PIN_RX_CLK] = rx_clk_in;
	assign pins_raw[PIN_SHIFT_CLK] = shift_clk_pin;
	assign pins_raw[PIN_RX_NRZ] = rx_nrz_in;
	assign pins_raw[PIN_RX_POS] = rx_pos_in;
	assign pins_raw[PIN_RX_NEG] = rx_neg_in;

	// data pins share the clock's latency, so launch and sample line up
	pin_sync #(
		.WIDTH(PIN_COUNT)
	) u_sync (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(pins_raw),
		.level(pins),
		.rise(pins_rise),
		.fall(pins_fall)
	);

	assign sel_now = pins[PIN_EDGE_SEL];
	assign mode_now = pins[PIN_MODE] ? MODE_DATA_RECOVERY : MODE_CLOCK_RECOVERY;

	// data changes on the opposite edge so it is stable on the chosen one
	assign rx_launch = launch_now(sel_now, pins_rise[PIN_RX_CLK], pins_fall[PIN_RX_CLK]);

	// read output changes on the edge opposite the sampling edge
	assign ser_launch = launch_now(~sel_now, pins_rise[PIN_SHIFT_CLK], pins_fall[PIN_SHIFT_CLK]);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.edge_sel = sel_now;
		st_nxt.mode = mode_now;
		unique case (mode_now)
			MODE_CLOCK_RECOVERY:
			begin
				st_nxt.rx_clk = pins[PIN_RX_CLK];
				if (rx_launch)
				begin
					st_nxt.nrz = pins[PIN_RX_NRZ];
					st_nxt.pos = pins[PIN_RX_POS];
					st_nxt.neg = pins[PIN_RX_NEG];
				end
			end
			MODE_DATA_RECOVERY:
			begin
				// no recovered clock here, so hold it quiet
				st_nxt.rx_clk = RX_CLK_RESET;
				st_nxt.nrz = sel_now ? pins[PIN_RX_NRZ] : ~pins[PIN_RX_NRZ];
				st_nxt.pos = sel_now ? pins[PIN_RX_POS] : ~pins[PIN_RX_POS];
				st_nxt.neg = sel_now ? pins[PIN_RX_NEG] : ~pins[PIN_RX_NEG];
			end
		endcase
		// enable follows the frame at once; bit waits for its launch edge
		st_nxt.ser_oe_n = ~read_active;
		if (ser_launch)
		begin
			st_nxt.ser_out = read_bit;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			st_r.edge_sel <= 1'h0;
			st_r.mode <= MODE_CLOCK_RECOVERY;
			st_r.rx_clk <= RX_CLK_RESET;
			st_r.nrz <= RX_DATA_RESET;
			st_r.pos <= RX_DATA_RESET;
			st_r.neg <= RX_DATA_RESET;
			st_r.ser_out <= SERIAL_OUT_RESET;
			st_r.ser_oe_n <= SERIAL_OE_N_RESET;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign rx_clk_out = st_r.rx_clk;
	assign rx_data_out = st_r.nrz;
	assign rx_positive_rail = st_r.pos;
	assign rx_negative_rail = st_r.neg;
	assign serial_read_output = st_r.ser_out;
	assign serial_read_oe_n = st_r.ser_oe_n;

	default clocking cb @(posedge core_clk);
	endclocking

	default disable iff (rst);

	// clock recovery passes the recovered clock through
	chk_clock_follow: assert property (
		mode_now == MODE_CLOCK_RECOVERY |=> rx_clk_out == $past(pins[PIN_RX_CLK])
	) else $error("receive clock output does not follow the recovered clock");

	// data recovery keeps the receive clock low for several cycles
	chk_clock_quiet: assert property (
		mode_now == MODE_DATA_RECOVERY [*3] |=> !rx_clk_out
	) else $error("receive clock output toggles in data recovery");

	// outputs hold across the rising output clock edge
	chk_rise_stable: assert property (
		st_r.mode == MODE_CLOCK_RECOVERY && $stable(st_r.mode) && !st_r.edge_sel
			&& $stable(st_r.edge_sel) && $rose(rx_clk_out)
			|-> $stable(rx_data_out) && $stable(rx_positive_rail) && $stable(rx_negative_rail)
	) else $error("receive data changed at rising clock edge with select low");

	// outputs hold across the falling output clock edge
	chk_fall_stable: assert property (
		st_r.mode == MODE_CLOCK_RECOVERY && $stable(st_r.mode) && st_r.edge_sel
			&& $stable(st_r.edge_sel) && $fell(rx_clk_out)
			|-> $stable(rx_data_out) && $stable(rx_positive_rail) && $stable(rx_negative_rail)
	) else $error("receive data changed at falling clock edge with select high");

	chk_low_polarity: assert property (
		mode_now == MODE_DATA_RECOVERY && !sel_now
			|=> rx_data_out == !$past(pins[PIN_RX_NRZ]) && rx_positive_rail == !$past(pins[PIN_RX_POS])
			&& rx_negative_rail == !$past(pins[PIN_RX_NEG])
	) else $error("receive outputs not active-low with select low");

	chk_high_polarity: assert property (
		mode_now == MODE_DATA_RECOVERY && sel_now
			|=> rx_data_out == $past(pins[PIN_RX_NRZ]) && rx_positive_rail == $past(pins[PIN_RX_POS])
			&& rx_negative_rail == $past(pins[PIN_RX_NEG])
	) else $error("receive outputs not active-high with select high");

	// read output changes on rising shift clock
	chk_serial_low: assert property (
		!sel_now && pins_rise[PIN_SHIFT_CLK] |=> serial_read_output == $past(read_bit)
	) else $error("serial read output not launched on rising shift edge with select low");

	// read output steady across the falling shift clock
	chk_serial_low_hold: assert property (
		!sel_now && pins_fall[PIN_SHIFT_CLK] |=> $stable(serial_read_output)
	) else $error("serial read output changed on falling shift edge with select low");

	// read output changes on falling shift clock
	chk_serial_high: assert property (
		sel_now && pins_fall[PIN_SHIFT_CLK] |=> serial_read_output == $past(read_bit)
	) else $error("serial read output not launched on falling shift edge with select high");

	// read output steady across the rising shift clock
	chk_serial_high_hold: assert property (
		sel_now && pins_rise[PIN_SHIFT_CLK] |=> $stable(serial_read_output)
	) else $error("serial read output changed on rising shift edge with select high");

endmodule : edge_select

// ===== frame_host.sv
/*
 * Far-side model: framer sampling the receive outputs and serial host
 * sampling the read output, each on its valid edge.
 * Assumes the edge select level is shared with the block and that
 * all signals are sampled by core_clk.
 */
`timescale 1ns/1ns
module frame_host
(
	// clock
	input wire logic core_clk,
	// shared select level
	input wire logic sel,
	// receive outputs of the block
	input wire logic rx_clk_out,
	input wire logic rx_data_out,
	input wire logic rx_positive_rail,
	input wire logic rx_negative_rail,
	// serial read side
	input wire logic shift_clk_pin,
	input wire logic serial_read_output,
	// captured values
	output logic [2:0] rx_cap,
	output logic sr_cap
);
	logic clk_q;
	logic sck_q;

	always_ff @(posedge core_clk)
	begin
		clk_q <= rx_clk_out;
		sck_q <= shift_clk_pin;
		if (rx_clk_out !== clk_q && rx_clk_out === ~sel)
			rx_cap <= {rx_data_out, rx_positive_rail, rx_negative_rail};
		if (shift_clk_pin !== sck_q && shift_clk_pin === sel)
			sr_cap <= serial_read_output;
	end
endmodule : frame_host

// ===== test_edge_select.sv
/*
 * Self-checking bench for the edge select block: data recovery table,
 * then clock recovery and serial reads for both select levels.
 * Assumes a three-edge pin-to-output latency in the block.
 */
`timescale 1ns/1ns
module test_edge_select;
	import edge_select_pkg::*;
	typedef struct {logic s; logic [2:0] i; logic [3:0] e;} row_t;
	logic core_clk = 1'h0, rst = 1'h1, sel = 1'h0, mode = 1'h0, rck = 1'h0, sck = 1'h0;
	logic rbit = 1'h0, ract = 1'h0, cap1, clk_o, d_o, p_o, n_o, so, oe_n;
	logic [2:0] din = 3'h0, cap3;
	int num_errors = 0, n_checks = 0;
	// {select, nrz/pos/neg in, expected clk/nrz/pos/neg out}
	row_t rows [4] = '{'{1'h0, 3'h5, 4'h2}, '{1'h0, 3'h0, 4'h7}, '{1'h1, 3'h5, 4'h5}, '{1'h1, 3'h6, 4'h6}};

	initial forever #2 core_clk = ~core_clk;

	edge_select u_edge_select (.core_clk(core_clk), .rst(rst), .edge_select_pin(sel), .data_recovery_pin(mode),
		.rx_clk_in(rck), .rx_nrz_in(din[2]), .rx_pos_in(din[1]), .rx_neg_in(din[0]), .rx_clk_out(clk_o),
		.rx_data_out(d_o), .rx_positive_rail(p_o), .rx_negative_rail(n_o), .shift_clk_pin(sck),
		.read_bit(rbit), .read_active(ract), .serial_read_output(so), .serial_read_oe_n(oe_n));
	frame_host u_frame_host (.core_clk(core_clk), .sel(sel), .rx_clk_out(clk_o), .rx_data_out(d_o),
		.rx_positive_rail(p_o), .rx_negative_rail(n_o), .shift_clk_pin(sck), .serial_read_output(so),
		.rx_cap(cap3), .sr_cap(cap1));

	task check(input logic [5:0] seen, input logic [5:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task results;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results

	task cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask : cyc

	// one 80 ns period of both clocks; data flips on the valid edge so a
	// launch on the wrong edge is caught by the far side
	task recov(input logic s, input logic [2:0] v, input logic chk);
		din = v;
		rck = s;
		rbit = v[0];
		sck = ~s;
		cyc(10);
		din = ~v;
		rck = ~s;
		rbit = ~v[0];
		sck = s;
		cyc(10);
		if (chk)
		begin
			check({3'h0, cap3}, {3'h0, v});
			check({5'h0, cap1}, {5'h0, v[0]});
			check({5'h0, oe_n}, 6'h00);
		end
	endtask : recov

	initial
	begin
		cyc(6);
		check({clk_o, d_o, p_o, n_o, so, oe_n}, 6'h01); // reset state
		rst = 1'h0;
		mode = 1'h1;
		foreach (rows[i])
		begin
			sel = rows[i].s;
			din = rows[i].i;
			cyc(4);
			check({2'h0, clk_o, d_o, p_o, n_o}, {2'h0, rows[i].e});
		end
		mode = 1'h0;
		ract = 1'h1;
		for (int s = 0; s < 2; s++)
		begin
			sel = s[0];
			// warm-up period after a select change
			recov(s[0], 3'h5, 1'h0);
			recov(s[0], 3'h2, 1'h1);
			recov(s[0], 3'h6, 1'h1);
			recov(s[0], 3'h1, 1'h1);
		end
		ract = 1'h0;
		cyc(4);
		check({5'h0, oe_n}, 6'h01);
		// second reset in mid-run, select still high
		rst = 1'h1;
		cyc(6);
		check({clk_o, d_o, p_o, n_o, so, oe_n}, 6'h01);
		rst = 1'h0;
		cyc(4);
		check({clk_o, d_o, p_o, n_o, so, oe_n}, 6'h01);
		results();
	end
endmodule : test_edge_select
